// *** hdl/chem_sum_engine.sv ***
// Sums the static chemistry table and compares against the stored sum
`timescale 1ns/1ns
`default_nettype none
module chem_sum_engine (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [14:0] storedSum,
  output logic done,
  output logic [14:0] sum,
  output logic mismatch
);
  import gauge_ctl_pkg::*;
  typedef struct packed {
    logic busy;
    logic [3:0] idx;
    logic [15:0] acc;
    logic done;
    logic [14:0] sum;
    logic mismatch;
  } eng_s;
  eng_s q, d;

  // One table word per cycle; the sum wraps at 16 bits before masking
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (q.busy) begin
      d.acc = q.acc + CHEM_TABLE[q.idx];
      d.idx = q.idx + 4'h1;
      if (q.idx == 4'hF) begin
        d.busy = 1'b0;
        d.done = 1'b1;
        d.sum = d.acc[14:0];
        d.mismatch = (d.acc[14:0] != storedSum);
      end
    end else if (start) begin
      d.busy = 1'b1;
      d.idx = 4'h0;
      d.acc = 16'h0000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) q <= '0;
    else q <= d;
  end

  assign done = q.done;
  assign sum = q.sum;
  assign mismatch = q.mismatch;
endmodule
`default_nettype wire

// *** hdl/gauge_control_subcommand_unit.sv ***
// Control command pair interpreter with its link-clock front end
`timescale 1ns/1ns
`default_nettype none
// Operation
// - A control pair write is followed by a subcommand choosing the function.
// - Status query places the status word in the control pair.
// - Type, firmware and hardware revision words returned; allowed while locked.
// - Reset count returned; refused while locked.
// - Previous subcommand returned; only values below the limit recorded.
// - Chemistry identifier and flash data revision returned; allowed while locked.
// - Board offset measured and stored with its calibration bit held.
// - Counter offset measured with its bit held; separate subcommand saves it.
// - Deep sleep flag set; oscillator stops once sleep is seen.
// - In deep sleep, drop first single-wire message, stretch two-wire 6-8 ms.
// - Any communication in deep sleep clears the flag and wakes to sleep.
// - Chemistry sum masked to 15 bits; top bit flags a mismatch.
// - Lock subcommand moves unlocked to locked.
// - Algorithm start when unlocked sets update bit, voltage-ok, capacity-enable.
// - Full reset only when unlocked.
// - Calibration mode enter, exit and toggle, shown in status.
// - Offset calibration reports counter offset in calibration mode.
// - Current subcommand returns instantaneous current; allowed while locked.
// - While locked only the allowed subcommands act.
// - Status word bit layout fixed, unused bits zero.
// - Constant-power bit follows gauging mode; it and calibration reset to zero; the code copies constantPowerIn into that bit and never resets it.
// - Charge percentage 0 to 100 and remaining capacity are read-only.
// - Each word takes two byte transactions.
// - Control pair read-write always; other pairs read-only always.
module gauge_control_subcommand_unit #(
  parameter int STRETCH_CYCLES = gauge_ctl_pkg::STRETCH_CYCLES,
  parameter int CAL_CYCLES = gauge_ctl_pkg::CAL_CYCLES
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic linkClk,
  input wire logic linkReqValid,
  input wire logic linkWrite,
  input wire logic [7:0] linkAddr,
  input wire logic [7:0] linkWdata,
  input wire logic linkSingleWire,
  output logic linkBusy,
  output logic linkRdValid,
  output logic [7:0] linkRdata,
  output logic linkDropped,
  input wire logic [15:0] socIn,
  input wire logic [15:0] remCapIn,
  input wire logic [15:0] currentIn,
  input wire logic [15:0] boardOffsetMeasIn,
  input wire logic [15:0] ccOffsetMeasIn,
  input wire logic [14:0] storedChemSum,
  input wire logic sleepIn,
  input wire logic constantPowerIn,
  input wire logic tableUpdateOffIn,
  input wire logic voltageUnsuitableIn,
  output logic oscStop,
  output logic gaugingOn,
  output logic [7:0] updateStatus,
  output logic calActive,
  output logic [15:0] boardOffset,
  output logic [15:0] ccOffsetSaved,
  output logic fullResetPulse
);
  import gauge_ctl_pkg::*;
  typedef struct packed {
    core_state_e state;
    logic [19:0] stretchCnt;
    link_req_s pend;
    logic [7:0] lowByte;
    logic [15:0] result;
    logic [15:0] lastSub;
    logic [15:0] resetCount;
    logic locked;
    logic full_access_locked_flag;
    logic calibration_active_flag;
    logic cca;
    logic bca;
    logic [7:0] calCnt;
    logic flash_checksum_valid_flag;
    logic deepSleep;
    logic oscStop;
    logic voltage_ok_for_capacity;
    logic capacity_update_enabled;
    logic gaugingOn;
    logic algBit;
    logic [15:0] boardOffset;
    logic [15:0] ccMeas;
    logic [15:0] ccSaved;
    logic chemStart;
    logic fullReset;
    logic rspPulse;
    logic rspDrop;
    logic [7:0] rspData;
  } core_s;

  typedef struct packed {
    logic busy;
    logic rdValid;
    logic [7:0] rdata;
    logic dropped;
  } link_s;

  core_s q, n;
  link_s lq, ln;
  logic [1:0] lnkRstQ;
  logic linkResetn;
  logic reqTake;
  logic reqPulse;
  link_req_s reqData;
  logic rspPulseL;
  logic [RSP_W-1:0] rspDataL;
  logic chemDone;
  logic [14:0] chemSum;
  logic chemMismatch;

  if (STRETCH_CYCLES < 1 || STRETCH_CYCLES > 1048575) $error("stretch count exceeds 20 bits");
  if (CAL_CYCLES < 1 || CAL_CYCLES > 256) $error("calibration count exceeds 8 bits");

  // Image loaded at power-up and by the full-reset subcommand
  function automatic core_s resetImage();
    core_s r;
    r = '0;
    r.state = CS_IDLE;
    r.locked = RESET_LOCKED;
    r.full_access_locked_flag = RESET_LOCKED;
    r.calibration_active_flag = 1'b0;
    r.result = RESET_WORD;
    return r;
  endfunction
  // Subcommands that still act while locked
  function automatic logic allowedLocked(input logic [15:0] sub);
    allowedLocked = (sub == SUB_STATUS) || (sub == SUB_DEVTYPE) || (sub == SUB_FWREV) ||
                    (sub == SUB_HWREV) || (sub == SUB_CHEMID) || (sub == SUB_DFREV) ||
                    (sub == SUB_CHEMSUM) || (sub == SUB_CURRENT);
  endfunction
  // Status word assembly; unused bits stay zero
  function automatic logic [15:0] statusWord(input core_s s, input logic slp,
                                             input logic cpwr, input logic rup);
    logic [15:0] w;
    w = '0;
    w[SB_FAS] = s.full_access_locked_flag;
    w[SB_LOCKED] = s.locked;
    w[SB_CALIBRATION_ACTIVE_FLAG] = s.calibration_active_flag;
    w[SB_CCA] = s.cca;
    w[SB_BCA] = s.bca;
    w[SB_CSV] = s.flash_checksum_valid_flag;
    w[SB_DEEPSLEEP] = s.deepSleep;
    w[SB_SLEEP] = slp;
    w[SB_CPWR] = cpwr;
    w[SB_RUPDIS] = rup;
    w[SB_VOK] = s.voltage_ok_for_capacity;
    w[SB_QEN] = s.capacity_update_enabled;
    return w;
  endfunction
  // Byte read decode; unmapped addresses read zero
  function automatic logic [7:0] readByte(input logic [7:0] a, input logic [15:0] res,
                                          input logic [15:0] soc, input logic [15:0] rem);
    logic [15:0] socC;
    socC = (soc > SOC_MAX) ? SOC_MAX : soc;
    if (a == ADDR_CTRL_LO) readByte = res[7:0];
    else if (a == ADDR_CTRL_HI) readByte = res[15:8];
    else if (a == ADDR_SOC_LO) readByte = socC[7:0];
    else if (a == ADDR_SOC_HI) readByte = socC[15:8];
    else if (a == ADDR_REM_LO) readByte = rem[7:0];
    else if (a == ADDR_REM_HI) readByte = rem[15:8];
    else readByte = 8'h00;
  endfunction
  // Link-domain reset follows core reset through two flops
  always_ff @(posedge linkClk) begin
    lnkRstQ <= {lnkRstQ[0], resetn};
  end
  assign linkResetn = lnkRstQ[1];

  // One byte transaction in flight; new requests wait for the reply
  assign reqTake = linkReqValid && !lq.busy;
  always_comb begin
    ln = lq;
    ln.rdValid = 1'b0;
    if (rspPulseL) begin
      ln.busy = 1'b0;
      ln.rdValid = 1'b1;
      ln.rdata = rspDataL[7:0];
      ln.dropped = rspDataL[8];
    end else if (reqTake) begin
      ln.busy = 1'b1;
    end
  end

  always_ff @(posedge linkClk) begin
    if (!linkResetn) lq <= '0;
    else lq <= ln;
  end

  toggle_xfer #(.WIDTH($bits(link_req_s))) reqXfer (
    .srcClk(linkClk),
    .srcResetn(linkResetn),
    .srcPulse(reqTake),
    .srcData({linkSingleWire, linkWrite, linkAddr, linkWdata}),
    .dstClk(core_clk),
    .dstResetn(resetn),
    .dstPulse(reqPulse),
    .dstData(reqData)
  );
  toggle_xfer #(.WIDTH(RSP_W)) rspXfer (
    .srcClk(core_clk),
    .srcResetn(resetn),
    .srcPulse(q.rspPulse),
    .srcData({q.rspDrop, q.rspData}),
    .dstClk(linkClk),
    .dstResetn(linkResetn),
    .dstPulse(rspPulseL),
    .dstData(rspDataL)
  );
  chem_sum_engine chemEngine (
    .core_clk(core_clk),
    .resetn(resetn),
    .start(q.chemStart),
    .storedSum(storedChemSum),
    .done(chemDone),
    .sum(chemSum),
    .mismatch(chemMismatch)
  );

  // Core: background events first, then the link transaction, so a request wins
  always_comb begin
    logic doReq;
    logic doFull;
    link_req_s cur;
    logic [15:0] sub;
    n = q;
    doReq = 1'b0;
    doFull = 1'b0;
    cur = q.pend;
    sub = 16'h0000;
    n.rspPulse = 1'b0;
    n.chemStart = 1'b0;
    n.fullReset = 1'b0;
    // Calibration windows end with the measurement captured
    if (q.bca || q.cca) begin
      if (q.calCnt == 8'h00) begin
        if (q.bca) n.boardOffset = boardOffsetMeasIn;
        else n.ccMeas = ccOffsetMeasIn;
        n.bca = 1'b0;
        n.cca = 1'b0;
      end else begin
        n.calCnt = q.calCnt - 8'h01;
      end
    end
    if (chemDone) begin
      n.result = {chemMismatch, chemSum};
      n.flash_checksum_valid_flag = !chemMismatch;
    end
    if (q.voltage_ok_for_capacity && voltageUnsuitableIn) n.voltage_ok_for_capacity = 1'b0;
    if (q.deepSleep && sleepIn) n.oscStop = 1'b1;
    case (q.state)
      CS_IDLE: begin
        if (reqPulse) begin
          n.deepSleep = 1'b0;
          n.oscStop = 1'b0;
          if (q.oscStop && reqData.singleWire) begin
            n.rspPulse = 1'b1;
            n.rspDrop = 1'b1;
            n.rspData = 8'h00;
          end else if (q.oscStop) begin
            n.pend = reqData;
            n.stretchCnt = 20'(STRETCH_CYCLES - 1);
            n.state = CS_STRETCH;
          end else begin
            doReq = 1'b1;
            cur = reqData;
          end
        end
      end
      CS_STRETCH: begin
        if (q.stretchCnt == 20'h00000) begin
          doReq = 1'b1;
          n.state = CS_IDLE;
        end else begin
          n.stretchCnt = q.stretchCnt - 20'h00001;
        end
      end
      default: n.state = CS_IDLE;
    endcase
    if (doReq) begin
      n.rspPulse = 1'b1;
      n.rspDrop = 1'b0;
      n.rspData = cur.write ? 8'h00 : readByte(cur.addr, q.result, socIn, remCapIn);
      if (cur.write && cur.addr == ADDR_CTRL_LO) begin
        n.lowByte = cur.wdata;
      end else if (cur.write && cur.addr == ADDR_CTRL_HI) begin
        sub = {cur.wdata, q.lowByte};
        if (sub < LAST_SUB_LIMIT) n.lastSub = sub;
        if (!q.locked || allowedLocked(sub)) begin
          case (sub)
            SUB_STATUS: n.result = statusWord(q, sleepIn, constantPowerIn,
                                              tableUpdateOffIn);
            SUB_DEVTYPE: n.result = DEVICE_TYPE_ID;
            SUB_FWREV: n.result = FW_REV_ID;
            SUB_HWREV: n.result = HW_REV_ID;
            SUB_RESETCNT: n.result = q.resetCount;
            SUB_LASTSUB: n.result = q.lastSub;
            SUB_CHEMID: n.result = CHEMISTRY_IDENTIFIER_QUERY_WORD;
            SUB_DFREV: n.result = DF_REV_ID;
            SUB_BOARDOFS: begin
              n.bca = 1'b1;
              n.cca = 1'b0;
              n.calCnt = 8'(CAL_CYCLES - 1);
            end
            SUB_CCOFS: begin
              n.cca = 1'b1;
              n.bca = 1'b0;
              n.calCnt = 8'(CAL_CYCLES - 1);
            end
            SUB_CCSAVE: n.ccSaved = q.ccMeas;
            SUB_DEEPSLEEP: n.deepSleep = 1'b1;
            SUB_CHEMSUM: n.chemStart = 1'b1;
            SUB_CURRENT: n.result = currentIn;
            SUB_LOCK: begin
              n.locked = 1'b1;
              n.full_access_locked_flag = 1'b1;
            end
            SUB_ALGSTART: begin
              n.gaugingOn = 1'b1;
              n.algBit = 1'b1;
              n.voltage_ok_for_capacity = 1'b1;
              n.capacity_update_enabled = 1'b1;
            end
            SUB_CALTOGGLE: n.calibration_active_flag = ~q.calibration_active_flag;
            SUB_CALEXIT: n.calibration_active_flag = 1'b0;
            SUB_CALENTER: n.calibration_active_flag = 1'b1;
            SUB_OFSCAL: begin
              if (q.calibration_active_flag) n.result = ccOffsetMeasIn;
            end
            SUB_FULLRESET: doFull = 1'b1;
            default: n.result = q.result;
          endcase
        end
      end
    end
    // Full reset keeps only the reset tally, and still answers the link
    if (doFull) begin
      n = resetImage();
      n.resetCount = q.resetCount + 16'h0001;
      n.fullReset = 1'b1;
      n.rspPulse = 1'b1;
      n.rspDrop = 1'b0;
      n.rspData = 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) q <= resetImage();
    else q <= n;
  end

  // Outputs straight from state flops
  assign linkBusy = lq.busy;
  assign linkRdValid = lq.rdValid;
  assign linkRdata = lq.rdata;
  assign linkDropped = lq.dropped;
  assign oscStop = q.oscStop;
  assign gaugingOn = q.gaugingOn;
  assign updateStatus = {5'b00000, q.algBit, 2'b00};
  assign calActive = q.calibration_active_flag;
  assign boardOffset = q.boardOffset;
  assign ccOffsetSaved = q.ccSaved;
  assign fullResetPulse = q.fullReset;
endmodule
`default_nettype wire

// *** hdl/gauge_ctl_pkg.sv ***
// Shared constants and types for the gauge control subcommand unit
package gauge_ctl_pkg;
  // Byte addresses of the word pairs on the link
  localparam logic [7:0] ADDR_CTRL_LO = 8'h00;
  localparam logic [7:0] ADDR_CTRL_HI = 8'h01;
  localparam logic [7:0] ADDR_SOC_LO = 8'h02;
  localparam logic [7:0] ADDR_SOC_HI = 8'h03;
  localparam logic [7:0] ADDR_REM_LO = 8'h04;
  localparam logic [7:0] ADDR_REM_HI = 8'h05;
  // Subcommand codes
  localparam logic [15:0] SUB_STATUS = 16'h0000;
  localparam logic [15:0] SUB_DEVTYPE = 16'h0001;
  localparam logic [15:0] SUB_FWREV = 16'h0002;
  localparam logic [15:0] SUB_HWREV = 16'h0003;
  localparam logic [15:0] SUB_RESETCNT = 16'h0005;
  localparam logic [15:0] SUB_LASTSUB = 16'h0007;
  localparam logic [15:0] SUB_CHEMID = 16'h0008;
  localparam logic [15:0] SUB_BOARDOFS = 16'h0009;
  localparam logic [15:0] SUB_CCOFS = 16'h000A;
  localparam logic [15:0] SUB_CCSAVE = 16'h000B;
  localparam logic [15:0] SUB_DFREV = 16'h000C;
  localparam logic [15:0] SUB_DEEPSLEEP = 16'h0010;
  localparam logic [15:0] SUB_CHEMSUM = 16'h0017;
  localparam logic [15:0] SUB_CURRENT = 16'h0018;
  localparam logic [15:0] SUB_LOCK = 16'h0020;
  localparam logic [15:0] SUB_ALGSTART = 16'h0021;
  localparam logic [15:0] SUB_CALTOGGLE = 16'h002D;
  localparam logic [15:0] SUB_FULLRESET = 16'h0041;
  localparam logic [15:0] SUB_CALEXIT = 16'h0080;
  localparam logic [15:0] SUB_CALENTER = 16'h0081;
  localparam logic [15:0] SUB_OFSCAL = 16'h0082;
  localparam logic [15:0] LAST_SUB_LIMIT = 16'h0020;
  // Status word bit positions
  localparam int SB_FAS = 14;
  localparam int SB_LOCKED = 13;
  localparam int SB_CALIBRATION_ACTIVE_FLAG = 12;
  localparam int SB_CCA = 11;
  localparam int SB_BCA = 10;
  localparam int SB_CSV = 9;
  localparam int SB_DEEPSLEEP = 5;
  localparam int SB_SLEEP = 4;
  localparam int SB_CPWR = 3;
  localparam int SB_RUPDIS = 2;
  localparam int SB_VOK = 1;
  localparam int SB_QEN = 0;
  localparam int UPDATE_ALG_BIT = 2;
  localparam logic [15:0] SOC_MAX = 16'h0064;
  // Reset values
  localparam logic RESET_LOCKED = 1'b0;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  // Timing
  localparam int CORE_CLK_KHZ = 50000;
  localparam int STRETCH_MIN_MS = 6;
  localparam int STRETCH_MAX_MS = 8;
  localparam int STRETCH_CYCLES = STRETCH_MIN_MS * CORE_CLK_KHZ;
  localparam int CAL_CYCLES = 64;
  // Identity words, values arbitrary
  localparam logic [15:0] DEVICE_TYPE_ID = 16'h5A01;
  localparam logic [15:0] FW_REV_ID = 16'h0101;
  localparam logic [15:0] HW_REV_ID = 16'h0055;
  localparam logic [15:0] CHEMISTRY_IDENTIFIER_QUERY_WORD = 16'h0100;
  localparam logic [15:0] DF_REV_ID = 16'h0001;
  // Static chemistry table walked by the checksum subcommand
  localparam logic [15:0] CHEM_TABLE [0:15] = '{
    16'h1A2B, 16'h0F3C, 16'h2244, 16'h7E01, 16'h0A0A, 16'h3C5D, 16'h4410, 16'h0099,
    16'h1111, 16'h2F2F, 16'h6001, 16'h0123, 16'h7777, 16'h0B0C, 16'h5E5E, 16'h0042};
  // Link request as carried across the clock boundary
  typedef struct packed {
    logic singleWire;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } link_req_s;
  localparam int RSP_W = 9;
  typedef enum logic [1:0] {
    CS_IDLE = 2'b01,
    CS_STRETCH = 2'b10
  } core_state_e;
endpackage

// *** hdl/toggle_xfer.sv ***
// Toggle handshake carrying one word from a source to a destination clock
`timescale 1ns/1ns
`default_nettype none
module toggle_xfer #(
  parameter int WIDTH = 8
) (
  input wire logic srcClk,
  input wire logic srcResetn,
  input wire logic srcPulse,
  input wire logic [WIDTH-1:0] srcData,
  input wire logic dstClk,
  input wire logic dstResetn,
  output logic dstPulse,
  output logic [WIDTH-1:0] dstData
);
  typedef struct packed {
    logic tog;
    logic [WIDTH-1:0] data;
  } src_s;
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } dst_s;
  src_s sq, sd;
  dst_s dq, dd;

  if (WIDTH < 1) $error("toggle_xfer width must be positive");

  // Data stays frozen until the next pulse, so the far side samples it safely
  always_comb begin
    sd = sq;
    if (srcPulse) begin
      sd.tog = ~sq.tog;
      sd.data = srcData;
    end
  end

  always_ff @(posedge srcClk) begin
    if (!srcResetn) sq <= '0;
    else sq <= sd;
  end

  // First stage feeds only the second
  always_comb begin
    dd.s1 = sq.tog;
    dd.s2 = dq.s1;
    dd.s3 = dq.s2;
  end

  always_ff @(posedge dstClk) begin
    if (!dstResetn) dq <= '0;
    else dq <= dd;
  end

  assign dstPulse = dq.s2 ^ dq.s3;
  assign dstData = sq.data;
endmodule
`default_nettype wire

// *** sim/gauge_unit_sva.sv ***
// Port assertions for the gauge control subcommand unit
`timescale 1ns/1ns
`default_nettype none
module gauge_unit_sva (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic linkClk,
  input wire logic linkReqValid,
  input wire logic linkBusy,
  input wire logic linkRdValid,
  input wire logic [15:0] boardOffsetMeasIn,
  input wire logic sleepIn,
  input wire logic oscStop,
  input wire logic gaugingOn,
  input wire logic [7:0] updateStatus,
  input wire logic [15:0] boardOffset,
  input wire logic fullResetPulse
);
  // Steps of one link byte transaction
  sequence takeS;
    linkReqValid && !linkBusy;
  endsequence
  sequence replyS;
    linkRdValid && !linkBusy;
  endsequence
  take_busy_a: assert property (@(posedge linkClk) disable iff (!resetn)
    takeS |=> linkBusy) else $error("busy missing after take");
  reply_bound_a: assert property (@(posedge linkClk) disable iff (!resetn)
    takeS |-> ##[2:200] replyS) else $error("no reply in time");
  reply_idle_a: assert property (@(posedge linkClk) disable iff (!resetn)
    linkRdValid |-> !linkBusy) else $error("reply while busy");
  reply_pulse_a: assert property (@(posedge linkClk) disable iff (!resetn)
    linkRdValid |=> !linkRdValid) else $error("reply too long");
  osc_cause_a: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(oscStop) |-> $past(sleepIn)) else $error("oscillator stop without sleep");
  update_bit_a: assert property (@(posedge core_clk) disable iff (!resetn)
    updateStatus == {5'h00, gaugingOn, 2'h0}) else $error("update status wrong");
  reset_pulse_a: assert property (@(posedge core_clk) disable iff (!resetn)
    fullResetPulse |=> !fullResetPulse && !gaugingOn) else $error("full reset wrong");
  // Zero is allowed since a full reset clears the stored offset
  board_cap_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !$stable(boardOffset) |->
    boardOffset == $past(boardOffsetMeasIn) || boardOffset == 16'h0000)
    else $error("board offset not measured");
endmodule
bind gauge_control_subcommand_unit gauge_unit_sva chk (.*);
`default_nettype wire

// *** sim/host_link_model.sv ***
// Host processor model issuing byte transactions on the link
`timescale 1ns/1ns
`default_nettype none
module host_link_model (
  input wire logic linkClk,
  input wire logic linkBusy,
  input wire logic linkRdValid,
  input wire logic [7:0] linkRdata,
  input wire logic linkDropped,
  output var logic linkReqValid,
  output var logic linkWrite,
  output var logic [7:0] linkAddr,
  output var logic [7:0] linkWdata,
  output var logic linkSingleWire
);
  initial begin
    linkReqValid = 1'b0;
    linkWrite = 1'b0;
    linkAddr = 8'h00;
    linkWdata = 8'h00;
    linkSingleWire = 1'b0;
  end
  // One byte, held until a free edge takes it; gap makes a slow host
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
    input int gap, input logic sw, output logic [7:0] q, output logic drop,
    output logic ok);
    int n;
    n = 0;
    repeat (gap + 1) @(posedge linkClk);
    #1;
    linkWrite = wr;
    linkAddr = a;
    linkWdata = d;
    linkSingleWire = sw;
    linkReqValid = 1'b1;
    while (linkBusy && n < 200) begin
      @(posedge linkClk);
      #1;
      n++;
    end
    @(posedge linkClk);
    #1;
    linkReqValid = 1'b0;
    // Released address and data lines show the inverse, never a stale copy
    linkWdata = ~d;
    linkAddr = ~a;
    while (!linkRdValid && n < 200) begin
      @(posedge linkClk);
      #1;
      n++;
    end
    q = linkRdata;
    drop = linkDropped;
    ok = n < 200;
  endtask
endmodule
`default_nettype wire

// *** sim/test_gauge_control_subcommand_unit.sv ***
// Self-checking bench for the gauge control subcommand unit
`timescale 1ns/1ns
`default_nettype none
module test_gauge_control_subcommand_unit;
  import gauge_ctl_pkg::*;
  localparam int STRETCH = 50;
  logic core_clk = 1'b0;
  logic linkClk = 1'b0;
  logic resetn = 1'b0;
  logic linkReqValid, linkWrite, linkSingleWire, linkBusy, linkRdValid, linkDropped;
  logic [7:0] linkAddr, linkWdata, linkRdata, updateStatus, q;
  logic [15:0] socIn, remCapIn, currentIn, boardOffsetMeasIn, ccOffsetMeasIn;
  logic [15:0] boardOffset, ccOffsetSaved, w, st;
  logic [14:0] storedChemSum;
  logic sleepIn, constantPowerIn, tableUpdateOffIn, voltageUnsuitableIn;
  logic oscStop, gaugingOn, calActive, fullResetPulse, drop, ok;
  logic [15:0] qs [6];
  logic [15:0] es [6];
  integer seed;
  int miscompares, cmp_count, i, v, rstCnt, rstSeen;
  gauge_control_subcommand_unit #(.STRETCH_CYCLES(STRETCH), .CAL_CYCLES(4)) dut (.*);
  host_link_model host (.*);
  // Core clock 50 MHz; link clock 80 ns at an unrelated phase
  always #10 core_clk = ~core_clk;
  // Full-reset pulses seen at the port, one per executed reset
  always @(posedge core_clk) begin
    if (fullResetPulse === 1'b1) rstSeen++;
  end
  initial begin
    #7;
    forever #40 linkClk = ~linkClk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Byte transfer through the host model; a hang ends the run
  task automatic bx(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic sw);
    host.xfer(wr, a, d, $random(seed) & 3, sw, q, drop, ok);
    if (!ok) begin
      miscompares++;
      wrap_up();
    end
  endtask
  // Low byte latches, high byte executes; wait covers calibration and sum
  task automatic sub(input logic [15:0] s);
    bx(1'b1, ADDR_CTRL_LO, s[7:0], 1'b0);
    bx(1'b1, ADDR_CTRL_HI, s[15:8], 1'b0);
    cyc(30);
  endtask
  task automatic rdw(input logic [7:0] a);
    bx(1'b0, a, 8'h00, 1'b0);
    w[7:0] = q;
    bx(1'b0, a + 8'h01, 8'h00, 1'b0);
    w[15:8] = q;
  endtask
  task automatic ask(input logic [15:0] s, input logic [15:0] e);
    sub(s);
    rdw(ADDR_CTRL_LO);
    check(w, e);
  endtask
  initial begin
    miscompares = 0;
    cmp_count = 0;
    repeat (100000) @(posedge core_clk);
    miscompares++;
    wrap_up();
  end
  initial begin
    seed = 32'h4D0B;
    rstCnt = 0;
    rstSeen = 0;
    v = $random(seed);
    {currentIn, remCapIn} = v;
    v = $random(seed);
    {ccOffsetMeasIn, boardOffsetMeasIn} = v;
    v = $random(seed);
    storedChemSum = v[14:0];
    constantPowerIn = v[16];
    tableUpdateOffIn = v[17];
    socIn = 16'h0000;
    sleepIn = 1'b0;
    voltageUnsuitableIn = 1'b0;
    st = {12'h000, constantPowerIn, tableUpdateOffIn, 2'b00};
    repeat (20) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    check({5'h00, gaugingOn, calActive, oscStop, updateStatus}, 16'h0000);
    repeat (4) @(posedge linkClk);
    // Read-only pairs, percentage clamp, refused write, unmapped byte
    for (i = 0; i < 2; i++) begin
      cyc(1);
      v = $random(seed) & 255;
      socIn = 16'(i ? 101 + v : v % 101);
      bx(1'b1, ADDR_SOC_LO, 8'hFF, 1'b0);
      rdw(ADDR_SOC_LO);
      check(w, 16'(i ? 100 : v % 101));
    end
    rdw(ADDR_REM_LO);
    check(w, remCapIn);
    bx(1'b0, 8'h07, 8'h00, 1'b0);
    check({8'h00, q}, 16'h0000);
    ask(SUB_STATUS, st);
    // Calibration mode enter, toggle twice, exit
    for (i = 0; i < 4; i++) begin
      sub(i == 3 ? SUB_CALEXIT : (i == 0 ? SUB_CALENTER : SUB_CALTOGGLE));
      check({15'h0000, calActive}, 16'(i % 2 == 0));
      ask(SUB_STATUS, st | 16'((i % 2 == 0) << 12));
      if (i == 2) ask(SUB_OFSCAL, ccOffsetMeasIn);
    end
    ask(SUB_OFSCAL, st);
    sub(SUB_BOARDOFS);
    check(boardOffset, boardOffsetMeasIn);
    sub(SUB_CCOFS);
    check(ccOffsetSaved, 16'h0000);
    sub(SUB_CCSAVE);
    check(ccOffsetSaved, ccOffsetMeasIn);
    sub(SUB_ALGSTART);
    check({gaugingOn, 7'h00, updateStatus}, 16'h8004);
    ask(SUB_LASTSUB, SUB_CCSAVE);
    ask(SUB_STATUS, st | 16'h0003);
    cyc(1);
    voltageUnsuitableIn = 1'b1;
    ask(SUB_STATUS, st | 16'h0001);
    // Sum first, then store it matching and off by one
    v = 0;
    for (i = 0; i < 16; i++) v += CHEM_TABLE[i];
    ask(SUB_CHEMSUM, {1'(storedChemSum != v[14:0]), v[14:0]});
    cyc(1);
    storedChemSum = v[14:0];
    ask(SUB_CHEMSUM, {1'b0, v[14:0]});
    ask(SUB_STATUS, st | 16'h0201);
    cyc(1);
    storedChemSum = storedChemSum ^ 15'h0001;
    ask(SUB_CHEMSUM, {1'b1, v[14:0]});
    ask(SUB_RESETCNT, 16'(rstCnt));
    sub(SUB_FULLRESET);
    rstCnt++;
    check(16'(rstSeen), 16'(rstCnt));
    check({15'h0000, gaugingOn}, 16'h0000);
    ask(SUB_RESETCNT, 16'(rstCnt));
    // Deep sleep: dropped single-wire message, then a stretched two-wire one
    sub(SUB_DEEPSLEEP);
    check({15'h0000, oscStop}, 16'h0000);
    sleepIn = 1'b1;
    cyc(3);
    check({15'h0000, oscStop}, 16'h0001);
    bx(1'b0, ADDR_CTRL_LO, 8'h00, 1'b1);
    check({14'h0000, drop, oscStop}, 16'h0002);
    ask(SUB_STATUS, st | 16'h0010);
    sub(SUB_DEEPSLEEP);
    cyc(3);
    v = int'($time);
    bx(1'b0, ADDR_CTRL_LO, 8'h00, 1'b0);
    check({14'h0000, drop, 1'($time - v >= STRETCH * 20)}, 16'h0001);
    cyc(1);
    sleepIn = 1'b0;
    // Locked: refused subcommands leave result and state alone
    sub(SUB_LOCK);
    st = st | 16'h6000;
    ask(SUB_STATUS, st);
    ask(SUB_RESETCNT, st);
    sub(SUB_ALGSTART);
    check({15'h0000, gaugingOn}, 16'h0000);
    qs = '{SUB_DEVTYPE, SUB_FWREV, SUB_HWREV, SUB_CHEMID, SUB_DFREV, SUB_CURRENT};
    es = '{DEVICE_TYPE_ID, FW_REV_ID, HW_REV_ID, CHEMISTRY_IDENTIFIER_QUERY_WORD, DF_REV_ID, currentIn};
    for (i = 0; i < 6; i++) begin
      ask(qs[i], es[i]);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
